// ---- verilog/phy_mgmt_register_subset.sv ----
// phy management register subset for two phys, reached by phy and register select
`timescale 1ns/100ps
`default_nettype none

module phy_mgmt_register_subset (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic req,
	input wire phy_mgmt_pkg::mgmt_req_s req_fields,
	output logic rvalid,
	output logic [15:0] rdata,
	input wire phy_mgmt_pkg::phy_status_s [1:0] phy_status,
	output phy_mgmt_pkg::phy_ctrl_s [1:0] phy_ctrl,
	output logic cable_start,
	input wire logic cable_done,
	input wire phy_mgmt_pkg::cable_result_s cable_result_in
);
	import phy_mgmt_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic phy_hit(input logic [4:0] sel);
		phy_hit = (sel == PHY_SEL_FIRST) || (sel == PHY_SEL_SECOND);
	endfunction

	function automatic logic phy_index(input logic [4:0] sel);
		phy_index = (sel == PHY_SEL_SECOND);
	endfunction

	// the cable register exists only behind the second phy
	function automatic logic cable_mapped(input logic [4:0] psel, input logic [4:0] rsel);
		cable_mapped = (psel == PHY_SEL_SECOND) && (rsel == REG_CABLE_TEST);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	phy_ctrl_s [1:0] ctrl;
	phy_ctrl_s [1:0] next_ctrl;
	phy_status_s [1:0] status;
	phy_status_s [1:0] next_status;
	cable_state_e cable_state;
	cable_state_e next_cable_state;
	cable_result_s cable_res;
	cable_result_s next_cable_res;
	logic next_cable_start;
	logic next_rvalid;
	logic [15:0] next_rdata;

	logic wr_hit;
	logic idx;

	assign wr_hit = req && req_fields.wr && phy_hit(req_fields.phy_select);
	assign idx = phy_index(req_fields.phy_select);

	////////////////////////////////////////////////////////////////////////////
	// control registers, shared with the switch-side view through phy_ctrl

	always_comb begin
		next_ctrl = ctrl;
		if (wr_hit && req_fields.reg_select == REG_ADVERTISE) begin
			next_ctrl[idx].adv_pause = req_fields.wdata[ADV_PAUSE_BIT];
			next_ctrl[idx].adv_res9 = req_fields.wdata[ADV_RES9_BIT];
			next_ctrl[idx].adv_abil = req_fields.wdata[ADV_ABIL_LSB +: 4];
		end
		if (wr_hit && req_fields.reg_select == REG_SPECIAL) begin
			next_ctrl[idx].force_link = req_fields.wdata[SP_FORCE_LINK_BIT];
			next_ctrl[idx].pwrsave_off = req_fields.wdata[SP_PWRSAVE_OFF_BIT];
			next_ctrl[idx].remote_loop = req_fields.wdata[SP_REMOTE_LOOP_BIT];
			next_ctrl[idx].reserved0 = req_fields.wdata[SP_RESERVED0_BIT];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_PHYS; i++) begin
				ctrl[i].adv_pause <= ADV_PAUSE_RESET;
				ctrl[i].adv_res9 <= 1'b0;
				ctrl[i].adv_abil <= ADV_ABIL_RESET;
				ctrl[i].force_link <= 1'b0;
				ctrl[i].pwrsave_off <= SP_PWRSAVE_OFF_RESET;
				ctrl[i].remote_loop <= 1'b0;
				ctrl[i].reserved0 <= 1'b0;
			end
		end else begin
			ctrl <= next_ctrl;
		end
	end

	assign phy_ctrl = ctrl;

	////////////////////////////////////////////////////////////////////////////
	// status capture from the phy cores

	always_comb begin
		next_status = phy_status;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cable test sequencing

	always_comb begin
		next_cable_state = cable_state;
		next_cable_res = cable_res;
		next_cable_start = 1'b0;
		case (cable_state)
			CT_IDLE: begin
				if (wr_hit && cable_mapped(req_fields.phy_select, req_fields.reg_select)
						&& req_fields.wdata[CT_LAUNCH_BIT]) begin
					next_cable_state = CT_RUN;
					next_cable_start = 1'b1;
				end
			end
			CT_RUN: begin
				// launch writes during a running test are ignored
				if (cable_done) begin
					next_cable_state = CT_IDLE;
					next_cable_res = cable_result_in;
				end
			end
			default: begin
				next_cable_state = CT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cable_state <= CT_IDLE;
			cable_res <= '0;
			cable_start <= 1'b0;
		end else begin
			cable_state <= next_cable_state;
			cable_res <= next_cable_res;
			cable_start <= next_cable_start;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path, one cycle after the request

	always_comb begin
		next_rvalid = req && !req_fields.wr;
		next_rdata = '0;
		if (req && !req_fields.wr && phy_hit(req_fields.phy_select)) begin
			case (req_fields.reg_select)
				REG_IDENT_LOW: begin
					next_rdata = IDENT_LOW_DEFAULT;
				end
				REG_ADVERTISE: begin
					next_rdata = {5'h00, ctrl[idx].adv_pause, ctrl[idx].adv_res9,
						ctrl[idx].adv_abil, ADV_SELECTOR};
				end
				REG_PARTNER: begin
					next_rdata = {5'h00, status[idx].lp_pause, 1'b0,
						status[idx].lp_abil, 5'h00};
				end
				REG_CABLE_TEST: begin
					if (cable_mapped(req_fields.phy_select, req_fields.reg_select)) begin
						next_rdata = {cable_state == CT_RUN, cable_res.outcome,
							cable_res.near_short_flag, 3'h0,
							cable_res.fault_count};
					end
				end
				REG_SPECIAL: begin
					next_rdata = {10'h000, status[idx].pol_reversed, status[idx].mdix,
						ctrl[idx].force_link, ctrl[idx].pwrsave_off,
						ctrl[idx].remote_loop, ctrl[idx].reserved0};
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid <= 1'b0;
			rdata <= '0;
		end else begin
			rvalid <= next_rvalid;
			rdata <= next_rdata;
		end
	end

endmodule // phy_mgmt_register_subset

`default_nettype wire

// ---- verilog/phy_mgmt_pkg.sv ----
// shared constants and carriers for the phy management register subset
package phy_mgmt_pkg;

	localparam int NUM_PHYS = 2;

	// phy and register selects
	localparam logic [4:0] PHY_SEL_FIRST = 5'h01;
	localparam logic [4:0] PHY_SEL_SECOND = 5'h02;
	localparam logic [4:0] REG_IDENT_LOW = 5'h03;
	localparam logic [4:0] REG_ADVERTISE = 5'h04;
	localparam logic [4:0] REG_PARTNER = 5'h05;
	localparam logic [4:0] REG_CABLE_TEST = 5'h1d;
	localparam logic [4:0] REG_SPECIAL = 5'h1f;

	// identifier low half; arbitrary value, not any real part's code
	localparam logic [15:0] IDENT_LOW_DEFAULT = 16'h5a3c;

	// advertisement fields
	localparam int ADV_PAUSE_BIT = 10;
	localparam int ADV_RES9_BIT = 9;
	localparam int ADV_ABIL_LSB = 5;
	localparam logic [4:0] ADV_SELECTOR = 5'h01;
	localparam logic ADV_PAUSE_RESET = 1'b1;
	localparam logic [3:0] ADV_ABIL_RESET = 4'hf;

	// cable test fields
	localparam int CT_LAUNCH_BIT = 15;

	// special control/status fields
	localparam int SP_FORCE_LINK_BIT = 3;
	localparam int SP_PWRSAVE_OFF_BIT = 2;
	localparam int SP_REMOTE_LOOP_BIT = 1;
	localparam int SP_RESERVED0_BIT = 0;
	localparam logic SP_PWRSAVE_OFF_RESET = 1'b1;

	typedef enum logic [0:0] {
		CT_IDLE = 1'b0,
		CT_RUN = 1'b1
	} cable_state_e;

	typedef struct packed {
		logic wr;
		logic [4:0] phy_select;
		logic [4:0] reg_select;
		logic [15:0] wdata;
	} mgmt_req_s;

	// order of abilities: 100 full, 100 half, 10 full, 10 half
	typedef struct packed {
		logic lp_pause;
		logic [3:0] lp_abil;
		logic pol_reversed;
		logic mdix;
	} phy_status_s;

	typedef struct packed {
		logic adv_pause;
		logic adv_res9;
		logic [3:0] adv_abil;
		logic force_link;
		logic pwrsave_off;
		logic remote_loop;
		logic reserved0;
	} phy_ctrl_s;

	typedef struct packed {
		logic [1:0] outcome;
		logic near_short_flag;
		logic [8:0] fault_count;
	} cable_result_s;

endpackage

// ---- verif/cable_far_end.sv ----
// far-side cable tester that answers each launch after lat cycles, or never when lat is zero
`timescale 1ns/100ps
`default_nettype none
module cable_far_end (
	input wire logic clk,
	input wire logic cable_start,
	input wire logic [7:0] lat,
	input wire phy_mgmt_pkg::cable_result_s res,
	output logic cable_done,
	output phy_mgmt_pkg::cable_result_s cable_result_in
);
	import phy_mgmt_pkg::*;
	logic [7:0] left = 8'h00;
	initial cable_done = 1'b0;
	always @(posedge clk) begin
		left <= cable_start ? lat : left - 8'(left != 8'h00);
		cable_done <= !cable_start && left == 8'h01;
	end
	// results hold only in the done cycle, an inverted pattern otherwise
	assign cable_result_in = cable_done ? res : ~res;
endmodule // cable_far_end
`default_nettype wire

// ---- verif/phy_mgmt_sva.sv ----
// port assertions for the phy management register subset
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_sva (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic req,
	input wire phy_mgmt_pkg::mgmt_req_s req_fields,
	input wire logic rvalid,
	input wire logic [15:0] rdata,
	input wire phy_mgmt_pkg::phy_ctrl_s [1:0] phy_ctrl,
	input wire logic cable_start
);
	import phy_mgmt_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire logic wr = req && req_fields.wr;
	wire logic rd = req && !req_fields.wr;
	wire logic p1 = req_fields.phy_select == PHY_SEL_FIRST;
	wire logic p2 = req_fields.phy_select == PHY_SEL_SECOND;
	wire logic [4:0] rs = req_fields.reg_select;
	wire logic [15:0] wd = req_fields.wdata;
	AST_IDENT: assert property (rd && p2 && rs == REG_IDENT_LOW
		|=> rvalid && rdata == IDENT_LOW_DEFAULT) else $error("ident read wrong");
	AST_PAUSE: assert property (wr && p1 && rs == REG_ADVERTISE
		|=> phy_ctrl[0].adv_pause == $past(wd[10])) else $error("pause not stored");
	AST_ABIL: assert property (wr && p2 && rs == REG_ADVERTISE
		|=> phy_ctrl[1].adv_abil == $past(wd[8:5])) else $error("abilities not stored");
	AST_SAVE: assert property (wr && p1 && rs == REG_SPECIAL
		|=> phy_ctrl[0].pwrsave_off == $past(wd[2])) else $error("saving not stored");
	AST_LOOP: assert property (wr && p2 && rs == REG_SPECIAL
		|=> phy_ctrl[1].remote_loop == $past(wd[1])) else $error("loop not stored");
	AST_START: assert property (cable_start
		|-> $past(wr && p2 && rs == REG_CABLE_TEST && wd[15])) else $error("stray start");
	AST_NO_START: assert property (wr && p1 && rs == REG_CABLE_TEST
		|=> !cable_start) else $error("first phy started a test");
	AST_NO_CABLE: assert property (rd && p1 && rs == REG_CABLE_TEST
		|=> rvalid && rdata == 16'h0000) else $error("first phy cable not zero");
endmodule // phy_mgmt_sva
bind phy_mgmt_register_subset phy_mgmt_sva chk (.clk, .reset_n, .req, .req_fields, .rvalid,
	.rdata, .phy_ctrl, .cable_start);
`default_nettype wire

// ---- verif/test_phy_mgmt_register_subset.sv ----
// self-checking bench for the phy management register subset
`timescale 1ns/100ps
`default_nettype none
module test_phy_mgmt_register_subset;
	import phy_mgmt_pkg::*;
	localparam logic [4:0] P1 = PHY_SEL_FIRST, P2 = PHY_SEL_SECOND;
	logic clk = 1'b0, reset_n = 1'b0, req = 1'b0, rvalid, cable_start, cable_done;
	mgmt_req_s req_fields = '0;
	phy_status_s [1:0] phy_status = '0;
	phy_ctrl_s [1:0] phy_ctrl;
	logic [15:0] rdata, got;
	logic [7:0] lat = 8'h01;
	cable_result_s res = '0, cable_result_in;
	int fail_count = 0, n_checks = 0, cyc = 0;
	phy_mgmt_register_subset DUT (.clk, .reset_n, .req, .req_fields, .rvalid, .rdata,
		.phy_status, .phy_ctrl, .cable_start, .cable_done, .cable_result_in);
	cable_far_end far (.clk, .cable_start, .lat, .res, .cable_done, .cable_result_in);
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic chk(input string name, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic ac(input logic w, input logic [4:0] p, r, input logic [15:0] d);
		@(posedge clk) #1;
		req = 1'b1;
		req_fields = '{w, p, r, d};
		@(posedge clk) #1;
		req = 1'b0;
		got = (rvalid === 1'b1) ? rdata : 16'hxxxx;
	endtask
	task automatic t_defaults;
		ac(1'b0, P1, REG_ADVERTISE, 16'h0000);
		chk("advertise", got, 16'h05e1);
		ac(1'b0, P2, REG_SPECIAL, 16'h0000);
		chk("special", got, 16'h0004);
		ac(1'b0, P1, REG_PARTNER, 16'h0000);
		chk("partner", got, 16'h0000);
	endtask
	task automatic t_advertise;
		ac(1'b1, P1, REG_ADVERTISE, 16'hffff);
		ac(1'b0, P1, REG_ADVERTISE, 16'h0000);
		chk("advertise all", got, 16'h07e1);
		ac(1'b1, P1, REG_ADVERTISE, 16'h0120);
		chk("pause out", {15'h0, phy_ctrl[0].adv_pause}, 16'h0000);
		chk("abil out", {12'h0, phy_ctrl[0].adv_abil}, 16'h0009);
		ac(1'b0, P1, REG_ADVERTISE, 16'h0000);
		chk("advertise some", got, 16'h0121);
		ac(1'b0, P2, REG_ADVERTISE, 16'h0000);
		chk("advertise other", got, 16'h05e1);
	endtask
	task automatic t_readonly;
		phy_status[1] = '{1'b1, 4'ha, 1'b1, 1'b1};
		phy_status[0] = '{1'b0, 4'h5, 1'b0, 1'b0};
		ac(1'b1, P2, REG_PARTNER, 16'hffff);
		ac(1'b1, P2, REG_IDENT_LOW, 16'hffff);
		ac(1'b0, P2, REG_PARTNER, 16'h0000);
		chk("partner two", got, 16'h0540);
		ac(1'b0, P1, REG_PARTNER, 16'h0000);
		chk("partner one", got, 16'h00a0);
		ac(1'b0, P2, REG_IDENT_LOW, 16'h0000);
		chk("ident", got, IDENT_LOW_DEFAULT);
		ac(1'b0, P2, REG_SPECIAL, 16'h0000);
		chk("special status", got, 16'h0034);
	endtask
	task automatic t_special;
		ac(1'b1, P1, REG_SPECIAL, 16'hffca);
		chk("loop out", {15'h0, phy_ctrl[0].remote_loop}, 16'h0001);
		chk("saving out", {15'h0, phy_ctrl[0].pwrsave_off}, 16'h0000);
		chk("force out", {15'h0, phy_ctrl[0].force_link}, 16'h0001);
		ac(1'b1, 5'h03, REG_SPECIAL, 16'h0000);
		chk("stray phy ignored", {15'h0, phy_ctrl[0].remote_loop}, 16'h0001);
		ac(1'b0, 5'h03, REG_ADVERTISE, 16'h0000);
		chk("stray phy read", got, 16'h0000);
		ac(1'b0, P1, REG_SPECIAL, 16'h0000);
		chk("special back", got, 16'h000a);
	endtask
	task automatic t_cable;
		ac(1'b1, P1, REG_CABLE_TEST, 16'h8000);
		chk("first start", {15'h0, cable_start}, 16'h0000);
		ac(1'b0, P1, REG_CABLE_TEST, 16'h0000);
		chk("first cable", got, 16'h0000);
		for (int o = 0; o < 4; o++) begin
			lat = 8'(1 + 6 * o);
			res = '{2'(o), o[0], 9'(16'h0a5 + 40 * o)};
			ac(1'b1, P2, REG_CABLE_TEST, 16'hffff);
			chk("start", {15'h0, cable_start}, 16'h0001);
			ac(1'b0, P2, REG_CABLE_TEST, 16'h0000);
			if (o > 0) begin
				chk("running", {15'h0, got[15]}, 16'h0001);
			end
			for (int n = 0; n < 50 && got[15] !== 1'b0; n++) begin
				ac(1'b0, P2, REG_CABLE_TEST, 16'h0000);
			end
			chk("cable", got, {1'b0, res.outcome, res.near_short_flag, 3'h0, res.fault_count});
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 reset_n = 1'b1;
		t_defaults();
		t_advertise();
		t_readonly();
		t_special();
		t_cable();
		close_out();
	end
endmodule // test_phy_mgmt_register_subset
`default_nettype wire
